// File: logic/windowed_watchdog_control.v
// Windowed watchdog with Wishbone register access and protected writes.
// Assumes fuse pins are static after power-on and restart comes from CPU logic on i_clk.
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/100ps
`include "dog_timer_defs.vh"

module windowed_watchdog_control #(
    parameter integer TICK_DIV    = `TICK_DIV_CYCLES,
    parameter [7:0]   PROTECT_KEY = 8'h5a // Arbitrary value
) (
    input  wire        i_clk,                 // 10 MHz system clock
    input  wire        i_sys_rst,             // Async reset, active high
    input  wire        i_wb_cyc,              // Wishbone cycle
    input  wire        i_wb_stb,              // Wishbone strobe
    input  wire        i_wb_we,               // Wishbone write enable
    input  wire [3:0]  i_wb_adr,              // Byte address
    input  wire [3:0]  i_wb_sel,              // Byte selects
    input  wire [31:0] i_wb_dat,              // Write data
    output reg  [31:0] o_wb_dat,              // Read data
    output reg         o_wb_ack,              // Acknowledge
    input  wire        i_restart,             // Restart instruction pulse
    input  wire [3:0]  i_timeout_fuse_default,// Timeout code fuses
    input  wire [3:0]  i_window_fuse_default, // Closed window code fuses
    input  wire        i_enable_fuse,         // Enable at power-on fuse
    input  wire        i_window_enable_fuse,  // Window mode at power-on fuse
    input  wire        i_lock_fuse,           // Lock fuse
    output reg         o_dog_reset            // System reset request, held
);

    ////////////////////////////////////////////////////////////////////////
    // Tick divider

    wire tick;

    dog_tick_gen #(
        .DIV (TICK_DIV)
    ) u_tick (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .o_tick    (tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Fuse pins: three flops, accept when stages two and three agree

    localparam integer FUSE_W = 11;

    wire [FUSE_W-1:0] fuse_pins;
    reg  [FUSE_W-1:0] fuse_s1_reg;
    reg  [FUSE_W-1:0] fuse_s2_reg;
    reg  [FUSE_W-1:0] fuse_s3_reg;
    reg  [FUSE_W-1:0] fuse_reg;

    assign fuse_pins = {i_lock_fuse, i_window_enable_fuse, i_enable_fuse,
                        i_window_fuse_default, i_timeout_fuse_default};

    genvar g;
    generate
        for (g = 0; g < FUSE_W; g = g + 1) begin : g_fuse_sync
            always @(posedge i_clk or posedge i_sys_rst) begin
                if (i_sys_rst) begin
                    fuse_s1_reg[g] <= 1'b0;
                    fuse_s2_reg[g] <= 1'b0;
                    fuse_s3_reg[g] <= 1'b0;
                    fuse_reg[g]    <= 1'b0;
                end else begin
                    fuse_s1_reg[g] <= fuse_pins[g];
                    fuse_s2_reg[g] <= fuse_s1_reg[g];
                    fuse_s3_reg[g] <= fuse_s2_reg[g];
                    if (fuse_s2_reg[g] == fuse_s3_reg[g]) begin
                        fuse_reg[g] <= fuse_s3_reg[g];
                    end
                end
            end
        end
    endgenerate

    wire locked;
    assign locked = fuse_reg[10];

    // Settings are held in load state until the fuse pins have settled
    // Agreed fuse value exists only after four edges, so load runs through the fifth
    reg  [2:0] load_cnt_reg;
    wire       loaded;
    assign loaded = (load_cnt_reg == `FUSE_LOAD_CYCLES);

    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            load_cnt_reg <= 3'h0;
        end else if (!loaded) begin
            load_cnt_reg <= load_cnt_reg + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wishbone slave, one wait state, ack for one cycle

    wire       wb_req;
    wire [1:0] wb_idx;
    wire       wb_wr;
    wire [7:0] wr_byte;

    assign wb_req  = i_wb_cyc & i_wb_stb;
    assign wb_idx  = i_wb_adr[3:2];
    assign wb_wr   = wb_req & i_wb_we & o_wb_ack & i_wb_sel[0];
    assign wr_byte = i_wb_dat[7:0];

    // Timed protection: key write opens writes for a few cycles
    reg  [2:0] protect_cnt_reg;
    wire       protect_open;
    assign protect_open = (protect_cnt_reg != 3'h0);

    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            protect_cnt_reg <= 3'h0;
        end else if (wb_wr && wb_idx == `IDX_PROTECT_KEY && wr_byte == PROTECT_KEY) begin
            protect_cnt_reg <= `PROTECT_OPEN_CYCLES;
        end else if (protect_open) begin
            protect_cnt_reg <= protect_cnt_reg - 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software-side settings and watchdog-side active settings

    reg  [3:0] sw_period_reg;
    reg        sw_enable_reg;
    reg  [3:0] sw_closed_reg;
    reg        sw_window_reg;
    reg  [3:0] act_period_reg;
    reg        act_enable_reg;
    reg  [3:0] act_closed_reg;
    reg        act_window_reg;
    reg        sync_pending_reg;

    wire ctrl_accept;
    wire win_accept;
    wire any_accept;

    // Unlock bit rides in the same write; protection must be open
    assign ctrl_accept = wb_wr && wb_idx == `IDX_DOG_CONTROL && protect_open
                         && wr_byte[`FLD_UNLOCK] && !locked;
    assign win_accept  = wb_wr && wb_idx == `IDX_WINDOW_CONTROL && protect_open
                         && wr_byte[`FLD_UNLOCK];
    assign any_accept  = ctrl_accept | win_accept;

    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sw_period_reg <= 4'h0;
            sw_enable_reg <= 1'b0;
            sw_closed_reg <= 4'h0;
            sw_window_reg <= 1'b0;
        end else if (!loaded) begin
            sw_period_reg <= fuse_reg[3:0];
            sw_closed_reg <= fuse_reg[7:4];
            sw_enable_reg <= fuse_reg[8];
            sw_window_reg <= fuse_reg[9];
        end else begin
            if (ctrl_accept) begin
                sw_period_reg <= wr_byte[`FLD_SEL_HI:`FLD_SEL_LO];
                sw_enable_reg <= wr_byte[`FLD_ENABLE];
            end
            if (win_accept) begin
                sw_window_reg <= wr_byte[`FLD_ENABLE];
                if (!locked) begin
                    sw_closed_reg <= wr_byte[`FLD_SEL_HI:`FLD_SEL_LO];
                end
            end
        end
    end

    // While stopped the new value lands one cycle after the write; while running it waits for a tick
    wire apply_direct;
    wire apply_sync;
    assign apply_direct = !act_enable_reg;
    assign apply_sync   = act_enable_reg & sync_pending_reg & tick;

    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sync_pending_reg <= 1'b0;
        end else if (any_accept && act_enable_reg) begin
            sync_pending_reg <= 1'b1;
        end else if (apply_sync || !act_enable_reg) begin
            sync_pending_reg <= 1'b0;
        end
    end

    // Copy taken one cycle late so it sees the freshly written settings
    reg copy_reg;
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            copy_reg <= 1'b0;
        end else begin
            copy_reg <= (!loaded) | (any_accept & apply_direct);
        end
    end

    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            act_period_reg <= 4'h0;
            act_enable_reg <= 1'b0;
            act_closed_reg <= 4'h0;
            act_window_reg <= 1'b0;
        end else if (copy_reg || apply_sync) begin
            act_period_reg <= sw_period_reg;
            act_enable_reg <= sw_enable_reg;
            act_closed_reg <= sw_closed_reg;
            act_window_reg <= sw_window_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register reads

    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h00000000;
        end else begin
            o_wb_ack <= wb_req & ~o_wb_ack;
            if (wb_req && !o_wb_ack) begin
                case (wb_idx)
                    `IDX_DOG_CONTROL: begin
                        o_wb_dat <= {26'h0000000, sw_period_reg, sw_enable_reg, 1'b0};
                    end
                    `IDX_WINDOW_CONTROL: begin
                        o_wb_dat <= {26'h0000000, sw_closed_reg, sw_window_reg, 1'b0};
                    end
                    `IDX_SYNC_STATUS: begin
                        o_wb_dat <= {31'h00000000, sync_pending_reg};
                    end
                    default: begin
                        o_wb_dat <= 32'h00000000;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Restart hand-over: held until the next tick consumes it

    reg restart_pending_reg;

    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            restart_pending_reg <= 1'b0;
        end else if (i_restart) begin
            restart_pending_reg <= 1'b1;
        end else if (tick) begin
            restart_pending_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Period counter and window phases

    localparam [1:0] ST_IDLE   = 2'h0;
    localparam [1:0] ST_CLOSED = 2'h1;
    localparam [1:0] ST_OPEN   = 2'h2;
    localparam [1:0] ST_FIRED  = 2'h3;

    reg  [1:0]  state_reg;
    reg  [1:0]  state_next;
    reg  [13:0] count_reg;
    reg  [13:0] count_next;
    reg         fire_next;

    wire        period_valid;
    wire        closed_valid;
    wire [13:0] period_len;
    wire [13:0] closed_len;
    wire        restart_now;
    wire [1:0]  start_state;

    assign period_valid = act_period_reg <= `SEL_MAX_VALID;
    assign closed_valid = act_closed_reg <= `SEL_MAX_VALID;
    assign period_len   = `PERIOD_BASE_TICKS << act_period_reg;
    assign closed_len   = `PERIOD_BASE_TICKS << act_closed_reg;
    assign restart_now  = tick & restart_pending_reg;
    // Closed window only in window mode with a valid code
    assign start_state  = (act_window_reg && closed_valid) ? ST_CLOSED : ST_OPEN;

    always @* begin
        state_next = state_reg;
        count_next = count_reg;
        fire_next  = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                count_next = 14'h0000;
                if (act_enable_reg) begin
                    state_next = start_state;
                end
            end
            ST_CLOSED: begin
                if (!act_enable_reg) begin
                    state_next = ST_IDLE;
                end else if (restart_now) begin
                    fire_next  = 1'b1;
                    state_next = ST_FIRED;
                end else if (tick) begin
                    if (count_reg == closed_len - 14'h0001) begin
                        count_next = 14'h0000;
                        state_next = ST_OPEN;
                    end else begin
                        count_next = count_reg + 14'h0001;
                    end
                end
            end
            ST_OPEN: begin
                if (!act_enable_reg) begin
                    state_next = ST_IDLE;
                end else if (restart_now) begin
                    count_next = 14'h0000;
                    state_next = start_state;
                end else if (tick && period_valid) begin
                    if (count_reg == period_len - 14'h0001) begin
                        fire_next  = 1'b1;
                        state_next = ST_FIRED;
                    end else begin
                        count_next = count_reg + 14'h0001;
                    end
                end
            end
            ST_FIRED: begin
                state_next = ST_FIRED;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Reset request holds until system reset clears it
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_reg   <= ST_IDLE;
            count_reg   <= 14'h0000;
            o_dog_reset <= 1'b0;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
            if (fire_next) begin
                o_dog_reset <= 1'b1;
            end
        end
    end

endmodule

// File: logic/dog_timer_defs.vh
// Constants shared by the watchdog control block and its tick divider.
// Assumes inclusion by bare name from files under logic/.
`ifndef DOG_TIMER_DEFS_VH
`define DOG_TIMER_DEFS_VH

// Timing: system clock and the 1 kHz watchdog tick
`define CLK_PERIOD_NS      100
`define TICK_PERIOD_NS     1000000
`define TICK_DIV_CYCLES    (`TICK_PERIOD_NS / `CLK_PERIOD_NS)

// Register word indices; byte address is four times the index
`define IDX_DOG_CONTROL    2'h0
`define IDX_WINDOW_CONTROL 2'h1
`define IDX_SYNC_STATUS    2'h2
`define IDX_PROTECT_KEY    2'h3

// Control field layout (shared by both control registers), plus the status pending bit
`define FLD_UNLOCK         0
`define FLD_ENABLE         1
`define FLD_SEL_LO         2
`define FLD_SEL_HI         5
`define FLD_SYNC_PENDING   0

// Period selection
`define SEL_MAX_VALID      4'ha
`define PERIOD_BASE_TICKS  14'h0008

// Configuration change protection
`define PROTECT_OPEN_CYCLES 3'h4

// Power-on fuse capture delay through the pin synchronisers
`define FUSE_LOAD_CYCLES   3'h5

`endif

// File: logic/dog_tick_gen.v
// Divider that turns the system clock into the 1 kHz watchdog tick enable.
// Assumes one free-running system clock; the tick is a one-cycle pulse.
`timescale 1ns/100ps
`include "dog_timer_defs.vh"

module dog_tick_gen #(
    parameter integer DIV = `TICK_DIV_CYCLES
) (
    input  wire i_clk,     // System clock
    input  wire i_sys_rst, // Async reset, active high
    output reg  o_tick     // One-cycle 1 kHz enable
);

    reg [15:0] count_reg;

    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            count_reg <= 16'h0000;
            o_tick    <= 1'b0;
        end else if (count_reg == DIV[15:0] - 16'h0001) begin
            count_reg <= 16'h0000;
            o_tick    <= 1'b1;
        end else begin
            count_reg <= count_reg + 16'h0001;
            o_tick    <= 1'b0;
        end
    end

endmodule

// File: dv/windowed_watchdog_control_asserts.sv
// Checker for the windowed watchdog control block, seeing only its ports.
// Assumes one clock domain and a bind from the testbench top file.
`timescale 1ns/100ps
module windowed_watchdog_control_asserts #(
    parameter integer TICK_DIV = 10
) (
    input wire        i_clk,                  // System clock
    input wire        i_sys_rst,              // Async reset, active high
    input wire        i_wb_cyc,               // Wishbone cycle
    input wire        i_wb_stb,               // Wishbone strobe
    input wire        i_wb_we,                // Wishbone write enable
    input wire [3:0]  i_wb_adr,               // Byte address
    input wire [31:0] o_wb_dat,               // Read data
    input wire        o_wb_ack,               // Acknowledge
    input wire [3:0]  i_timeout_fuse_default, // Timeout code fuses
    input wire        i_lock_fuse,            // Lock fuse
    input wire        o_dog_reset             // System reset request
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    wire       rd_ack = o_wb_ack && !i_wb_we;
    reg [31:0] up_cnt_reg;

    // Cycles since reset release; saturates so long runs cannot wrap
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst)
            up_cnt_reg <= 32'h0;
        else if (up_cnt_reg != 32'hffffffff)
            up_cnt_reg <= up_cnt_reg + 32'h1;
    end

    sequence s_req;
        i_wb_cyc && i_wb_stb && !o_wb_ack;
    endsequence
    sequence s_ans;
        o_wb_ack ##1 !o_wb_ack;
    endsequence

    ////////////////////////////////////////////////////////////////////////////
    chk_bus_answer: assert property (s_req |=> s_ans)
        else $error("request not answered by a single ack");
    chk_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack longer than one cycle");
    chk_reset_sticky: assert property (o_dog_reset |=> o_dog_reset)
        else $error("watchdog reset dropped");
    chk_unlock_zero: assert property (rd_ack && i_wb_adr[3:2] != 2'h2 |-> !o_wb_dat[0])
        else $error("unlock bit reads back set");
    chk_status_clean: assert property (rd_ack && i_wb_adr[3:2] == 2'h2 |-> o_wb_dat[31:1] == 31'h0)
        else $error("status spare bits set");
    chk_ctrl_upper: assert property (rd_ack && !i_wb_adr[3] |-> o_wb_dat[31:6] == 26'h0)
        else $error("control spare bits set");
    chk_lock_frozen: assert property (rd_ack && i_wb_adr[3:2] == 2'h0 && i_lock_fuse
        |-> o_wb_dat[5:2] == i_timeout_fuse_default)
        else $error("locked timeout code changed");
    chk_tick_floor: assert property ($rose(o_dog_reset) |-> up_cnt_reg >= 8 * TICK_DIV)
        else $error("reset before eight ticks");
endmodule

// File: dv/tb_top.sv
// Self-checking bench for the windowed watchdog control block.
// Assumes a shortened tick divider; most waits are fixed cycle counts sized for a TD of 10, only t_timeout scales with TD.
`timescale 1ns/100ps
module tb_top;
    localparam integer TD = 10;
    reg        i_clk = 0, i_sys_rst = 1, cyc = 0, stb = 0, we = 0, rs = 0, en_f = 0, wen_f = 0, lk = 0;
    reg [3:0]  adr = 4'h0, sel = 4'h0, tf = 4'h2, wf = 4'h1;
    reg [31:0] wd = 32'h0;
    reg [7:0]  q;
    wire [31:0] rd;
    wire        ack, dr;
    integer     n_fail = 0, n_checks = 0, s;

    windowed_watchdog_control #(.TICK_DIV(TD)) u_windowed_watchdog_control (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wd), .o_wb_dat(rd), .o_wb_ack(ack),
        .i_restart(rs), .i_timeout_fuse_default(tf), .i_window_fuse_default(wf),
        .i_enable_fuse(en_f), .i_window_enable_fuse(wen_f), .i_lock_fuse(lk), .o_dog_reset(dr));

    initial begin
        forever #50 i_clk = ~i_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task chk(input [8*8-1:0] nm, input [7:0] exp, input [7:0] got);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("BAD %0s expected %h seen %h", nm, exp, got);
        end
    endtask
    task wb(input w, input [3:0] a, input [7:0] d);
        begin
            @(posedge i_clk);
            cyc <= 1; stb <= 1; we <= w; adr <= a; sel <= 4'hf; wd <= {24'h0, d};
            // Waits for ack however long it takes; only the run time limit ends a hang
            do @(posedge i_clk); while (ack !== 1'b1);
            q = rd[7:0];
            cyc <= 0; stb <= 0;
        end
    endtask
    // Key write immediately ahead keeps the target inside the open span
    task key_wr(input [3:0] a, input [7:0] d);
        wb(1, 4'hc, 8'h5a);
        wb(1, a, d);
    endtask
    task wait_n(input integer n);
        repeat (n) @(posedge i_clk);
    endtask
    task pulse;
        @(posedge i_clk) rs <= 1;
        @(posedge i_clk) rs <= 0;
    endtask
    task boot(input l);
        @(posedge i_clk) begin lk <= l; i_sys_rst <= 1; end
        wait_n(8);
        i_sys_rst <= 0;
        wait_n(8);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task t_fuse_guard;
        boot(0);
        wb(0, 4'h0, 0); chk("ctrl", 8'h08, q);
        wb(0, 4'h4, 0); chk("win", 8'h04, q);
        wb(1, 4'h0, 8'h0b); wb(0, 4'h0, 0); chk("nokey", 8'h08, q);
        key_wr(4'h0, 8'h0a); wb(0, 4'h0, 0); chk("nounlk", 8'h08, q);
        key_wr(4'h4, 8'h06); wb(0, 4'h4, 0); chk("wnounlk", 8'h04, q);
        key_wr(4'h4, 8'h09); wb(0, 8, 0); chk("stopped", 8'h00, q);
        wb(0, 4'h4, 0); chk("wunlk", 8'h08, q);
    endtask
    task t_timeout(input [3:0] c);
        integer w;
        begin
            boot(0);
            w = (8 << c) * TD;
            key_wr(4'h0, {2'b00, c, 2'b11});
            wait_n(1);
            // Second write lands on a tick edge while running, so pending stands a full tick
            key_wr(4'h0, {2'b00, c, 2'b11}); wb(0, 4'h8, 0); chk("pending", 8'h01, q);
            wait_n(2 * TD); wb(0, 4'h8, 0); chk("synced", 8'h00, q);
            wait_n(w - 30 - 2 * TD); chk("early", 8'h00, {7'h0, dr});
            wait_n(50); chk("expired", 8'h01, {7'h0, dr});
        end
    endtask
    task t_reserved;
        boot(0);
        key_wr(4'h0, 8'h2f); wait_n(1000); chk("rsvd", 8'h00, {7'h0, dr});
        key_wr(4'h4, 8'h2f); key_wr(4'h0, 8'h03);
        wait_n(30); pulse; wait_n(40); chk("noclose", 8'h00, {7'h0, dr});
        wait_n(100); chk("openend", 8'h01, {7'h0, dr});
    endtask
    task t_restart;
        boot(0);
        key_wr(4'h0, 8'h03);
        repeat (8) begin
            wait_n(40);
            pulse;
        end
        chk("kept", 8'h00, {7'h0, dr});
        wait_n(100); chk("lapsed", 8'h01, {7'h0, dr});
    endtask
    task t_disable;
        boot(0);
        key_wr(4'h0, 8'h03); wait_n(30); key_wr(4'h0, 8'h01);
        wait_n(200); chk("off", 8'h00, {7'h0, dr});
    endtask
    task t_window(input integer at, input [7:0] exp);
        boot(0);
        key_wr(4'h4, 8'h07); key_wr(4'h0, 8'h03);
        wait_n(at); pulse; wait_n(40); chk("window", exp, {7'h0, dr});
    endtask
    task t_lock;
        boot(1);
        key_wr(4'h0, 8'h0f); wb(0, 4'h0, 0); chk("lckctrl", 8'h08, q);
        key_wr(4'h4, 8'h03); wb(0, 4'h4, 0); chk("lckwin", 8'h06, q);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task wrap_up;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        t_fuse_guard;
        for (s = 0; s < 3; s = s + 1) t_timeout(s[3:0]);
        t_reserved;
        t_restart;
        t_disable;
        t_window(50, 8'h01);
        t_window(200, 8'h00);
        t_lock;
        wrap_up;
    end
    // Whole run is a few thousand cycles; this margin is ample
    initial begin
        #(100 * 30000);
        n_fail = n_fail + 1;
        wrap_up;
    end
endmodule

bind windowed_watchdog_control windowed_watchdog_control_asserts #(.TICK_DIV(TICK_DIV)) u_asserts (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
    .i_timeout_fuse_default(i_timeout_fuse_default), .i_lock_fuse(i_lock_fuse),
    .o_dog_reset(o_dog_reset));
